// file: core/ebrh_defines.vh
// Constants for the external bus ready and hold arbitration block
`ifndef EBRH_DEFINES_VH
`define EBRH_DEFINES_VH

// Register byte offsets
`define EBRH_OFF_CTRL 8'h00
`define EBRH_OFF_CMD 8'h04
`define EBRH_OFF_ADDR 8'h08
`define EBRH_OFF_WDATA 8'h0C
`define EBRH_OFF_STATUS 8'h10
`define EBRH_OFF_RDATA 8'h14

// Control register fields
`define EBRH_CTRL_RDYEN 0
`define EBRH_CTRL_ASYNC 1
`define EBRH_CTRL_POL 2
`define EBRH_CTRL_ARBEN 3
`define EBRH_CTRL_LEN_LSB 4
`define EBRH_CTRL_LEN_MSB 8
`define EBRH_CTRL_MASK 32'h0000_01FF
`define EBRH_CTRL_RST 32'h0000_0000

// Command register fields
`define EBRH_CMD_START 0
`define EBRH_CMD_WRITE 1
`define EBRH_CMD_CLRDONE 2

// Address and data registers
`define EBRH_HALF_MASK 32'h0000_FFFF
`define EBRH_WORD_RST 32'h0000_0000

// Status register fields
`define EBRH_ST_BUSY 0
`define EBRH_ST_GRANT 1
`define EBRH_ST_DEVICE_BUS_REQUEST_OUT 2
`define EBRH_ST_DONE 3
`define EBRH_ST_PEND 4
`define EBRH_ST_STATE_LSB 5
`define EBRH_ST_STATE_MSB 7

// AXI responses
`define EBRH_RESP_OKAY 2'h0
`define EBRH_RESP_SLVERR 2'h2

// Reference clock half period in system clocks
`define EBRH_REF_HALF 8

`endif

// file: core/ebrh_sync.v
// Two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module ebrh_sync #(
  parameter W = 1
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Data
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// file: core/ebrh_top.v
// External bus cycle control with READY handshake and hold arbitration
//
// Contract
// - Read data captured on the edge that raises the read strobe.
// - An early address change never disturbs the captured read data.
// - Read data are not used after the read strobe rises.
// - External READY lengthens or ends the running bus cycle.
// - READY polarity is selectable and READY is read by that polarity.
// - Asynchronous READY passes an extra stage, costing one waitstate minimum.
// - READY inactive at sample point inserts one waitstate, then samples again.
// - READY active at sample point ends the running cycle.
// - Synchronous and asynchronous READY sample at different points.
// - Mandatory access waitstates finish before READY is evaluated.
// - Hold requests are honoured only while arbitration is enabled.
// - The running bus cycle completes before the bus is granted.
// - On release, controls are driven inactive, then float; ALE stays low.
// - On regain, controls go from floating to driven inactive; ALE low.
// - Regain starts only when the hold request goes high.
// - Hold may drop without a bus request; regain proceeds normally.
// - Own bus request is asserted only after the bus is released.
// - Next own bus cycle starts only after regain completes.
// - READY stretches only the access phase of 1 to 32 units.
//
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/100ps
`include "ebrh_defines.vh"
module ebrh_top #(
  parameter AW = 8,
  parameter DIVW = 4,
  parameter REF_HALF = `EBRH_REF_HALF
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address
  input wire [AW-1:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [AW-1:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // External bus
  output reg reference_clock_output,
  output reg [15:0] bus_addr,
  output reg bus_addr_oe,
  output reg [15:0] bus_wdata,
  output reg bus_data_oe,
  input wire [15:0] bus_rdata_in,
  output reg bus_rd_n,
  output reg bus_wr_n,
  output reg bus_ale,
  output reg bus_ctrl_oe,
  input wire bus_ready_in,
  // Arbitration
  input wire hold_req_n,
  output reg bus_grant_acknowledge_n,
  output reg device_bus_request_out_n
);
  localparam S_IDLE = 3'h0;
  localparam S_ADDR = 3'h1;
  localparam S_ACC = 3'h2;
  localparam S_RDYW = 3'h3;
  localparam S_HOLD = 3'h4;
  localparam S_REL = 3'h5;
  localparam S_FLOAT = 3'h6;
  localparam S_REG = 3'h7;
  localparam [DIVW-1:0] DIV_LAST = REF_HALF[DIVW-1:0] - 1'b1;

  reg [DIVW-1:0] div_q;
  reg [2:0] state_q;
  reg [4:0] acc_q;
  reg [31:0] ctrl_q;
  reg [31:0] addr_q;
  reg [31:0] wdat_q;
  reg [15:0] rcap_q;
  reg pend_q;
  reg write_q;
  reg done_q;
  reg a1_q;
  reg a2_q;
  reg [AW-1:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  wire [17:0] sync_q;
  wire rdy_s;
  wire hold_s;
  wire [15:0] rdat_s;
  wire rise_tick;
  wire fall_tick;
  wire rdy_act;
  wire rdy_ok;
  wire hold_req;
  wire in_cycle;
  wire wr_go;
  wire cmd_wr;
  wire cmd_start;
  wire cmd_clr;
  wire done_set;
  wire [4:0] acc_len;
  reg [31:0] rd_mux;
  reg rd_err;

  // Pins cross into the system clock domain
  ebrh_sync #(
    .W(18)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({bus_ready_in, hold_req_n, bus_rdata_in}),
    .q(sync_q)
  );
  assign rdy_s = sync_q[17];
  assign hold_s = sync_q[16];
  assign rdat_s = sync_q[15:0];

  // Byte-lane merge for register writes
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  // Reference clock divider; all bus phases move on its rising edge
  always @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= {DIVW{1'b0}};
      reference_clock_output <= 1'b0;
    end else if (div_q == DIV_LAST) begin
      div_q <= {DIVW{1'b0}};
      reference_clock_output <= ~reference_clock_output;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end
  assign rise_tick = (div_q == DIV_LAST) & ~reference_clock_output;
  assign fall_tick = (div_q == DIV_LAST) & reference_clock_output;

  assign rdy_act = ctrl_q[`EBRH_CTRL_POL] ? rdy_s : ~rdy_s;

  always @(posedge aclk) begin
    if (!aresetn) begin
      a1_q <= 1'b0;
      a2_q <= 1'b0;
    end else begin
      if (fall_tick) begin
        a1_q <= rdy_act;
      end
      if (rise_tick) begin
        a2_q <= a1_q;
      end
    end
  end
  assign rdy_ok = ctrl_q[`EBRH_CTRL_ASYNC] ? a2_q : rdy_act;

  assign hold_req = ctrl_q[`EBRH_CTRL_ARBEN] & ~hold_s;
  assign acc_len = ctrl_q[`EBRH_CTRL_LEN_MSB:`EBRH_CTRL_LEN_LSB];
  assign in_cycle = (state_q == S_ADDR) | (state_q == S_ACC) | (state_q == S_RDYW) |
                    (state_q == S_HOLD);

  // Write is performed once address and data are both held
  assign wr_go = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  assign cmd_wr = wr_go & (awaddr_q == `EBRH_OFF_CMD) & wstrb_q[0];
  // Start while busy is ignored
  assign cmd_start = cmd_wr & wdata_q[`EBRH_CMD_START] & ~pend_q & ~in_cycle;
  assign cmd_clr = cmd_wr & wdata_q[`EBRH_CMD_CLRDONE];
  assign done_set = rise_tick & (state_q == S_HOLD);

  // AXI4-Lite write side
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `EBRH_RESP_OKAY;
      awaddr_q <= {AW{1'b0}};
      wdata_q <= `EBRH_WORD_RST;
      wstrb_q <= 4'h0;
      ctrl_q <= `EBRH_CTRL_RST;
      addr_q <= `EBRH_WORD_RST;
      wdat_q <= `EBRH_WORD_RST;
    end else begin
      if (s_axi_awready & s_axi_awvalid) begin
        s_axi_awready <= 1'b0;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wready & s_axi_wvalid) begin
        s_axi_wready <= 1'b0;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `EBRH_RESP_OKAY;
        case (awaddr_q)
          `EBRH_OFF_CTRL: begin
            ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q) & `EBRH_CTRL_MASK;
          end
          `EBRH_OFF_CMD: begin
          end
          `EBRH_OFF_ADDR: begin
            addr_q <= merge(addr_q, wdata_q, wstrb_q) & `EBRH_HALF_MASK;
          end
          `EBRH_OFF_WDATA: begin
            wdat_q <= merge(wdat_q, wdata_q, wstrb_q) & `EBRH_HALF_MASK;
          end
          `EBRH_OFF_STATUS, `EBRH_OFF_RDATA: begin
          end
          default: begin
            s_axi_bresp <= `EBRH_RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Read mux
  always @* begin
    rd_mux = `EBRH_WORD_RST;
    rd_err = 1'b0;
    case (s_axi_araddr)
      `EBRH_OFF_CTRL: rd_mux = ctrl_q;
      `EBRH_OFF_CMD: rd_mux = `EBRH_WORD_RST;
      `EBRH_OFF_ADDR: rd_mux = addr_q;
      `EBRH_OFF_WDATA: rd_mux = wdat_q;
      `EBRH_OFF_STATUS: begin
        rd_mux[`EBRH_ST_BUSY] = pend_q | in_cycle;
        rd_mux[`EBRH_ST_GRANT] = ~bus_grant_acknowledge_n;
        rd_mux[`EBRH_ST_DEVICE_BUS_REQUEST_OUT] = ~device_bus_request_out_n;
        rd_mux[`EBRH_ST_DONE] = done_q;
        rd_mux[`EBRH_ST_PEND] = pend_q;
        rd_mux[`EBRH_ST_STATE_MSB:`EBRH_ST_STATE_LSB] = state_q;
      end
      `EBRH_OFF_RDATA: rd_mux[15:0] = rcap_q;
      default: rd_err = 1'b1;
    endcase
  end

  // AXI4-Lite read side
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `EBRH_WORD_RST;
      s_axi_rresp <= `EBRH_RESP_OKAY;
    end else begin
      if (s_axi_arready & s_axi_arvalid) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_err ? `EBRH_RESP_SLVERR : `EBRH_RESP_OKAY;
      end
      if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Done flag; a completing cycle beats a clear in the same clock
  always @(posedge aclk) begin
    if (!aresetn) begin
      done_q <= 1'b0;
    end else if (done_set) begin
      done_q <= 1'b1;
    end else if (cmd_clr) begin
      done_q <= 1'b0;
    end
  end

  // Bus cycle and arbitration sequencer
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= S_IDLE;
      acc_q <= 5'h0;
      pend_q <= 1'b0;
      write_q <= 1'b0;
      rcap_q <= 16'h0000;
      bus_addr <= 16'h0000;
      bus_addr_oe <= 1'b1;
      bus_wdata <= 16'h0000;
      bus_data_oe <= 1'b0;
      bus_rd_n <= 1'b1;
      bus_wr_n <= 1'b1;
      bus_ale <= 1'b0;
      bus_ctrl_oe <= 1'b1;
      bus_grant_acknowledge_n <= 1'b1;
      device_bus_request_out_n <= 1'b1;
    end else begin
      if (cmd_start) begin
        pend_q <= 1'b1;
        write_q <= wdata_q[`EBRH_CMD_WRITE];
      end
      if (rise_tick) begin
        case (state_q)
          S_IDLE: begin
            if (hold_req) begin
              state_q <= S_REL;
            end else if (pend_q) begin
              pend_q <= 1'b0;
              bus_addr <= addr_q[15:0];
              bus_wdata <= wdat_q[15:0];
              bus_ale <= 1'b1;
              state_q <= S_ADDR;
            end
          end
          S_ADDR: begin
            bus_ale <= 1'b0;
            bus_rd_n <= write_q;
            bus_wr_n <= ~write_q;
            bus_data_oe <= write_q;
            acc_q <= 5'h0;
            state_q <= S_ACC;
          end
          S_ACC: begin
            if (acc_q != acc_len) begin
              acc_q <= acc_q + 5'h1;
            end else if (!ctrl_q[`EBRH_CTRL_RDYEN] || rdy_ok) begin
              bus_rd_n <= 1'b1;
              bus_wr_n <= 1'b1;
              if (!write_q) begin
                rcap_q <= rdat_s;
              end
              state_q <= S_HOLD;
            end else begin
              state_q <= S_RDYW;
            end
          end
          S_RDYW: begin
            if (rdy_ok) begin
              bus_rd_n <= 1'b1;
              bus_wr_n <= 1'b1;
              if (!write_q) begin
                rcap_q <= rdat_s;
              end
              state_q <= S_HOLD;
            end
          end
          S_HOLD: begin
            bus_data_oe <= 1'b0;
            state_q <= S_IDLE;
          end
          S_REL: begin
            bus_ctrl_oe <= 1'b0;
            bus_addr_oe <= 1'b0;
            bus_ale <= 1'b0;
            bus_grant_acknowledge_n <= 1'b0;
            state_q <= S_FLOAT;
          end
          S_FLOAT: begin
            if (hold_s) begin
              bus_grant_acknowledge_n <= 1'b1;
              device_bus_request_out_n <= 1'b1;
              bus_ctrl_oe <= 1'b1;
              bus_addr_oe <= 1'b1;
              state_q <= S_REG;
            end else begin
              device_bus_request_out_n <= ~pend_q;
            end
          end
          S_REG: begin
            bus_ale <= 1'b0;
            state_q <= S_IDLE;
          end
          default: begin
            state_q <= S_IDLE;
          end
        endcase
      end
    end
  end
endmodule

// file: sim/ebrh_asserts.sv
// Concurrent checks on the bus cycle and hold pins
`timescale 1ns/100ps
module ebrh_asserts #(
  parameter REF_HALF = 8
) (
  // Clock and reset
  input logic aclk,
  input logic aresetn,
  // Bus pins
  input logic reference_clock_output,
  input logic bus_addr_oe,
  input logic bus_rd_n,
  input logic bus_wr_n,
  input logic bus_ale,
  input logic bus_ctrl_oe,
  // Arbitration
  input logic hold_req_n,
  input logic bus_grant_acknowledge_n,
  input logic device_bus_request_out_n
);
  int rc_q;
  int sc_q;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Zero until the first toggle, so a partial half period is never judged
  always @(posedge aclk) begin
    if (!aresetn) begin
      rc_q <= 0;
      sc_q <= 0;
    end else begin
      rc_q <= $changed(reference_clock_output) ? 1 : (rc_q == 0 ? 0 : rc_q + 1);
      sc_q <= (bus_rd_n && bus_wr_n) ? 0 : sc_q + 1;
    end
  end
  sequence s_float;
    !bus_ctrl_oe && !bus_addr_oe && !bus_ale;
  endsequence
  sequence s_drv_idle;
    bus_ctrl_oe && bus_rd_n && bus_wr_n && !bus_ale && bus_grant_acknowledge_n;
  endsequence
  a_ref_half: assert property (
    $changed(reference_clock_output) && rc_q != 0 |-> rc_q == REF_HALF)
    else $error("Reference half period wrong");
  a_strobe_min: assert property (
    $rose(bus_rd_n && bus_wr_n) |-> sc_q >= 2 * REF_HALF)
    else $error("Strobe shorter than one unit");
  a_strobe_tick: assert property (
    $fell(bus_rd_n) || $fell(bus_wr_n) |-> $rose(reference_clock_output))
    else $error("Strobe fell off the tick");
  a_strobe_end: assert property (
    $rose(bus_rd_n) || $rose(bus_wr_n) |-> $rose(reference_clock_output))
    else $error("Strobe rose off the tick");
  a_float_quiet: assert property (
    !bus_ctrl_oe |-> !bus_ale && bus_rd_n && bus_wr_n)
    else $error("Floating controls not inactive");
  a_release_order: assert property (
    $fell(bus_ctrl_oe) |-> $past(bus_rd_n) && $past(bus_wr_n) && !$past(bus_ale))
    else $error("Released before driving inactive");
  a_grant_float: assert property (
    !bus_grant_acknowledge_n |-> s_float)
    else $error("Acknowledge while bus driven");
  a_device_bus_request_out_granted: assert property (
    !device_bus_request_out_n |-> !bus_grant_acknowledge_n)
    else $error("Bus request before release");
  a_regain_hold: assert property (
    $rose(bus_grant_acknowledge_n) |-> $past(hold_req_n, 3))
    else $error("Regain without hold going high");
  a_regain_drive: assert property (
    $rose(bus_ctrl_oe) |-> s_drv_idle ##1 s_drv_idle)
    else $error("Regain not driven inactive");
endmodule

bind ebrh_top ebrh_asserts #(.REF_HALF(REF_HALF)) u_chk (.aclk, .aresetn,
  .reference_clock_output, .bus_addr_oe, .bus_rd_n, .bus_wr_n, .bus_ale, .bus_ctrl_oe,
  .hold_req_n, .bus_grant_acknowledge_n, .device_bus_request_out_n);

// file: sim/ebrh_far_model.sv
// Far side model: small memory with a READY responder
`timescale 1ns/100ps
module ebrh_far_model (
  // Clocks
  input logic aclk,
  input logic rclk,
  // Bus pins
  input logic [15:0] addr,
  input logic [15:0] wdata,
  input logic rd_n,
  input logic wr_n,
  output logic [15:0] rdata,
  output logic ready,
  // Settings
  input logic pol,
  input int k
);
  logic [15:0] mem [16];
  logic rp_q = 0;
  logic wp_q = 1;
  int cnt_q = 0;
  wire act = !(rd_n && wr_n) && cnt_q >= k;
  // Dropped as soon as the strobe rises
  assign ready = pol ? act : !act;
  // Released lines show inverted data, not the last value
  assign rdata = rd_n ? ~mem[addr[3:0]] : mem[addr[3:0]];
  // Moves only after reference ticks, held to strobe end
  always @(posedge aclk) begin
    rp_q <= rclk;
    wp_q <= wr_n;
    if (wr_n && !wp_q)
      mem[addr[3:0]] <= wdata;
    if (rd_n && wr_n)
      cnt_q <= 0;
    else if (rclk && !rp_q)
      cnt_q <= cnt_q + 1;
  end
endmodule

// file: sim/ebrh_tb_top.sv
// Testbench for bus cycle control and hold arbitration
`timescale 1ns/100ps
`include "ebrh_defines.vh"
module ebrh_tb_top;
  localparam int UNIT = 4;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, hold_req_n = 1, pol = 1;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, v;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [15:0] bus_addr, bus_wdata, bus_rdata_in, far_d;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic reference_clock_output, bus_addr_oe, bus_data_oe, bus_rd_n, bus_wr_n, bus_ale;
  logic bus_ctrl_oe, bus_ready_in, bus_grant_acknowledge_n, device_bus_request_out_n;
  int k = 0, failures = 0, tests_run = 0, low_q = 0, last_low = 0;
  initial forever #5 aclk = ~aclk;
  // Short reference period keeps the long access phases quick
  ebrh_top #(.REF_HALF(2)) u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .reference_clock_output, .bus_addr, .bus_addr_oe,
    .bus_wdata, .bus_data_oe, .bus_rdata_in, .bus_rd_n, .bus_wr_n, .bus_ale,
    .bus_ctrl_oe, .bus_ready_in, .hold_req_n, .bus_grant_acknowledge_n,
    .device_bus_request_out_n);
  ebrh_far_model u_far (.aclk, .rclk(reference_clock_output), .addr(bus_addr),
    .wdata(bus_wdata), .rd_n(bus_rd_n), .wr_n(bus_wr_n), .rdata(far_d),
    .ready(bus_ready_in), .pol, .k);
  assign bus_rdata_in = bus_data_oe ? bus_wdata : far_d;
  always @(posedge aclk) begin
    low_q <= (bus_rd_n && bus_wr_n) ? 0 : low_q + 1;
    if (bus_rd_n && bus_wr_n && low_q != 0)
      last_low <= low_q;
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task rng(input int g, input int lo, input int hi);
    tests_run++;
    if (g < lo || g > hi) begin
      failures++;
      $display("CHECK FAILED t=%0t length %0d", $time, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw, w;
    aw = 0;
    w = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw = 1;
        s_axi_awvalid <= 0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w = 1;
        s_axi_wvalid <= 0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  task automatic wt(ref logic s, input logic e);
    int n;
    n = 0;
    while (s !== e && n < 400) begin
      @(posedge aclk);
      n++;
    end
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t wait timed out", $time);
    end
  endtask
  task automatic dn;
    int n;
    n = 0;
    do begin
      rd(`EBRH_OFF_STATUS, v, rsp);
      n++;
    end while (v[`EBRH_ST_DONE] !== 1'b1 && n < 400);
    if (v[`EBRH_ST_DONE] !== 1'b1) begin
      failures++;
      $display("CHECK FAILED t=%0t cycle never done", $time);
    end
  endtask
  task cyc(input logic w, input logic [15:0] d);
    wr(`EBRH_OFF_ADDR, 32'h0000_0005, rsp);
    wr(`EBRH_OFF_WDATA, {16'h0000, d}, rsp);
    wr(`EBRH_OFF_CMD, w ? 32'h0000_0007 : 32'h0000_0005, rsp);
    dn;
  endtask
  task t_regs;
    rd(`EBRH_OFF_CTRL, v, rsp);
    chk(v, `EBRH_CTRL_RST);
    wr(`EBRH_OFF_CTRL, 32'hFFFF_FFFF, rsp);
    rd(`EBRH_OFF_CTRL, v, rsp);
    chk(v, `EBRH_CTRL_MASK);
    rd(8'h18, v, rsp);
    chk(rsp, `EBRH_RESP_SLVERR);
    wr(8'h18, 32'h0000_0001, rsp);
    chk(rsp, `EBRH_RESP_SLVERR);
    $display("register test done");
  endtask
  task t_rdy(input logic [31:0] c, input int kk, input int lo, input int hi,
             input logic [15:0] d);
    k <= kk;
    pol <= c[`EBRH_CTRL_POL];
    wr(`EBRH_OFF_CTRL, c, rsp);
    cyc(1, d);
    rng(last_low, lo * UNIT, hi * UNIT);
    cyc(0, d);
    rng(last_low, lo * UNIT, hi * UNIT);
    rd(`EBRH_OFF_RDATA, v, rsp);
    chk(v, {16'h0000, d});
    $display("ready test done");
  endtask
  task t_hold;
    k <= 3;
    wr(`EBRH_OFF_CTRL, 32'h0000_000D, rsp);
    wr(`EBRH_OFF_CMD, 32'h0000_0005, rsp);
    wt(bus_rd_n, 0);
    chk({bus_addr_oe, bus_ale, bus_addr}, {2'b10, 16'h0005});
    hold_req_n <= 0;
    wt(bus_grant_acknowledge_n, 0);
    rd(`EBRH_OFF_STATUS, v, rsp);
    chk(v[`EBRH_ST_DONE], 1);
    wr(`EBRH_OFF_CMD, 32'h0000_0007, rsp);
    wt(device_bus_request_out_n, 0);
    chk(device_bus_request_out_n, 0);
    rd(`EBRH_OFF_STATUS, v, rsp);
    chk(v[`EBRH_ST_DONE], 0);
    hold_req_n <= 1;
    wt(bus_grant_acknowledge_n, 1);
    wt(bus_wr_n, 0);
    chk({bus_data_oe, bus_wdata}, {1'b1, 16'h7FFE});
    dn;
    chk(last_low, 3 * UNIT);
    hold_req_n <= 0;
    wt(bus_grant_acknowledge_n, 0);
    hold_req_n <= 1;
    wt(bus_grant_acknowledge_n, 1);
    chk(bus_ctrl_oe, 1);
    wr(`EBRH_OFF_CTRL, 32'h0000_0005, rsp);
    hold_req_n <= 0;
    repeat (40) @(posedge aclk);
    chk(bus_grant_acknowledge_n, 1);
    hold_req_n <= 1;
    $display("hold test done");
  endtask
  task results;
    $display("tests %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    t_regs;
    t_rdy(32'h0000_0005, 0, 1, 1, 16'h1234);
    t_rdy(32'h0000_0005, 3, 3, 3, 16'hA55A);
    t_rdy(32'h0000_0001, 3, 3, 3, 16'h0FF0);
    t_rdy(32'h0000_0007, 3, 4, 5, 16'h5AA5);
    t_rdy(32'h0000_0025, 0, 3, 3, 16'h8001);
    t_rdy(32'h0000_01F4, 40, 32, 32, 16'h7FFE);
    t_hold;
    results;
  end
  // Far longer than the whole sequence needs
  initial begin
    #200000;
    failures++;
    results;
  end
endmodule
